// ### three_phase_pwm_controller.sv
// three-phase center-based pwm generator with dead time, pulse deletion,
// crossover, per-output enables, gate chopping and shutdown.
// assumes a single ahb-lite master on sys_clk; trip, polarity and gpio
// pins are asynchronous to sys_clk.
//
// What this block does
// - drives three high/low output pairs, one per motor phase.
// - polarity pin selects active-high or active-low output patterns.
// - period, dead time and minimum pulse set by their own registers.
// - three duty registers each set one pair's duty cycle.
// - each of six outputs has its own enable bit in segment control.
// - per-pair crossover bit swaps high and low signal routing.
// - outputs mixed with chopping signal, frequency from 8-bit gate field.
// - chopping enabled separately for high-side and low-side outputs.
// - single update mode loads new values once per period, symmetric pattern.
// - double update mode also loads at period midpoint, allowing asymmetry.
// - one mode-control bit selects single or double update.
// - that bit is bit 6, clear means single, resets clear.
// - one sync pulse at every period start in single mode.
// - double mode adds a sync pulse at each period midpoint.
// - sync width is clock period times (width register + 1), reset 0x27.
// - dead time is 10-bit value times two clocks; zero gives none.
// - timing unit makes complementary center-based pairs with dead time.
// - trip pin low forces all outputs off at once, level per polarity.
// - enabled gpio lines act as extra asynchronous trip sources.
// - hardware shutdown path bypasses all clocked logic.
// - software trip write shuts outputs down like hardware sources.
// - shutdown controller handles all sources and resets the timing unit.
// - status shows trip and polarity pin levels and half-period flag.
// - half flag is status bit 3, clear first half, set second.
// - all timing is counted in sys_clk periods.
// - interrupt pulse on each sync rising edge and on any shutdown.
`timescale 1ns/1ns

module three_phase_pwm_controller #(
  parameter int GPIO_W = 12
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // pins
  input  wire logic                trip_input_pin_n,
  input  wire logic                polarity_select_pin,
  input  wire logic [GPIO_W-1:0]   gpio_lines,
  output logic                     phase_a_high_out,
  output logic                     phase_a_low_out,
  output logic                     phase_b_high_out,
  output logic                     phase_b_low_out,
  output logic                     phase_c_high_out,
  output logic                     phase_c_low_out,
  output logic                     sync_pulse_out,
  output logic                     sync_irq,
  output logic                     shutdown_irq
);
  import pwm_pkg::*;

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [15:0]          period_register;
  logic [DEAD_W-1:0]    dead_time_register;
  logic [15:0]          pulse_deletion_register;
  logic [SYNCW_W-1:0]   sync_width_register;
  logic [2:0][15:0]     duty_reg;
  logic [8:0]           output_segment_control;
  logic [9:0]           gate_chopping_register;
  logic                 double_mode;
  logic [GPIO_W-1:0]    io_shutdown_enable;

  logic                 wr_pend;
  logic [7:0]           wr_addr;
  logic                 sw_trip_set;
  logic                 sw_trip_clr;
  logic                 shut_latched;
  logic                 half;
  logic [1:0]           trip_s;
  logic [1:0]           pol_s;
  logic [1:0][GPIO_W-1:0] gpio_s;

  wire logic addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // writes land in the data phase, when hwdata is valid
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      period_register         <= PERIOD_RST;
      dead_time_register      <= '0;
      pulse_deletion_register <= '0;
      sync_width_register     <= SYNCW_RST;
      duty_reg                <= '0;
      output_segment_control  <= SEG_RST;
      gate_chopping_register  <= '0;
      double_mode             <= 1'b0;
      io_shutdown_enable      <= '0;
    end else if (wr_pend) begin
      unique case (wr_addr)
        ADDR_PERIOD:   period_register         <= hwdata[15:0];
        ADDR_DEAD:     dead_time_register      <= hwdata[DEAD_W-1:0];
        ADDR_PDEL:     pulse_deletion_register <= hwdata[15:0];
        ADDR_SYNCW:    sync_width_register     <= hwdata[SYNCW_W-1:0];
        ADDR_DUTY_A:   duty_reg[0]             <= hwdata[15:0];
        ADDR_DUTY_B:   duty_reg[1]             <= hwdata[15:0];
        ADDR_DUTY_C:   duty_reg[2]             <= hwdata[15:0];
        ADDR_SEGMENT:  output_segment_control  <= hwdata[8:0];
        ADDR_GATE:     gate_chopping_register  <= hwdata[9:0];
        ADDR_MODE:     double_mode             <= hwdata[MODE_DOUBLE];
        ADDR_IO_SD_EN: io_shutdown_enable      <= hwdata[GPIO_W-1:0];
        default:       ;
      endcase
    end
  end

  always_comb begin
    sw_trip_set = wr_pend && (wr_addr == ADDR_SW_TRIP) && hwdata[SWT_TRIP_BIT];
    sw_trip_clr = wr_pend && (wr_addr == ADDR_SW_TRIP) && !hwdata[SWT_TRIP_BIT];
  end

  // read data is registered in the address phase so hrdata is a flop output
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_PERIOD:   hrdata <= {16'h0000, period_register};
        ADDR_DEAD:     hrdata <= {22'h000000, dead_time_register};
        ADDR_PDEL:     hrdata <= {16'h0000, pulse_deletion_register};
        ADDR_SYNCW:    hrdata <= {24'h000000, sync_width_register};
        ADDR_DUTY_A:   hrdata <= {16'h0000, duty_reg[0]};
        ADDR_DUTY_B:   hrdata <= {16'h0000, duty_reg[1]};
        ADDR_DUTY_C:   hrdata <= {16'h0000, duty_reg[2]};
        ADDR_SEGMENT:  hrdata <= {23'h000000, output_segment_control};
        ADDR_GATE:     hrdata <= {22'h000000, gate_chopping_register};
        ADDR_MODE:     hrdata <= {25'h0000000, double_mode, 6'h00};
        ADDR_IO_SD_EN: hrdata <= {{(32-GPIO_W){1'b0}}, io_shutdown_enable};
        ADDR_STATUS:   hrdata <= {28'h0000000, half, shut_latched,
                                  pol_s[1], trip_s[1]};
        default:       hrdata <= '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;   // zero wait states once out of reset
      hresp     <= 1'b0;
    end
  end

  // ****************************************************************
  // pin synchronisers and shutdown controller
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trip_s <= 2'b11;
      pol_s  <= 2'b00;
      gpio_s <= '1;
    end else begin
      trip_s <= {trip_s[0], trip_input_pin_n};
      pol_s  <= {pol_s[0], polarity_select_pin};
      gpio_s <= {gpio_s[0], gpio_lines};
    end
  end

  logic hw_trip_s;
  logic shut_now;
  always_comb begin
    hw_trip_s = !trip_s[1] || |(~gpio_s[1] & io_shutdown_enable);
    shut_now  = hw_trip_s || sw_trip_set;
  end

  // a trip stays latched until software clears it; a new trip wins over the clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shut_latched <= 1'b0;
      shutdown_irq <= 1'b0;
    end else begin
      if (shut_now) begin
        shut_latched <= 1'b1;
      end else if (sw_trip_clr) begin
        shut_latched <= 1'b0;
      end
      shutdown_irq <= shut_now && !shut_latched;
    end
  end

  // ****************************************************************
  // timing unit
  // ****************************************************************
  pwm_cfg_s    cfg;
  logic [15:0] half_cnt;
  logic        restart;
  logic        half_end;
  logic        load;
  logic [8:0]  sync_cnt;

  always_comb begin
    half_end = ({1'b0, half_cnt} + 17'd1) >= {1'b0, cfg.period};
    load     = restart || (half_end && (half || double_mode));
  end

  // shutdown holds the counter at the start of a period
  always_ff @(posedge sys_clk) begin
    if (sys_rst || shut_latched) begin
      half_cnt <= '0;
      half     <= 1'b0;
      restart  <= 1'b1;
    end else begin
      restart <= 1'b0;
      if (restart || half_end) begin
        half_cnt <= '0;
        half     <= !restart && !half;
      end else begin
        half_cnt <= half_cnt + 16'd1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg <= '{period: PERIOD_RST, dead: '0, pdel: '0, syncw: SYNCW_RST,
               duty: '0, seg: SEG_RST};
    end else if (load && !shut_latched) begin
      cfg <= '{period: period_register, dead: dead_time_register,
               pdel: pulse_deletion_register, syncw: sync_width_register,
               duty: duty_reg, seg: output_segment_control};
    end
  end

  // sync is set high on every load, so once per period or twice in double mode
  always_ff @(posedge sys_clk) begin
    if (sys_rst || shut_latched) begin
      sync_pulse_out <= 1'b0;
      sync_cnt       <= '0;
      sync_irq       <= 1'b0;
    end else begin
      // a load while sync is still high makes no rising edge, so no interrupt
      sync_irq <= load && !sync_pulse_out;
      if (load) begin
        sync_pulse_out <= 1'b1;
        sync_cnt       <= {1'b0, sync_width_register};
      end else if (sync_cnt == 9'h000) begin
        sync_pulse_out <= 1'b0;
      end else begin
        sync_cnt <= sync_cnt - 9'd1;
      end
    end
  end

  // ****************************************************************
  // per-phase waveform, dead time and output control
  // ****************************************************************
  logic [7:0]  chop_cnt;
  logic        chop;
  logic [5:0]  drive;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      chop_cnt <= '0;
      chop     <= 1'b0;
    end else if (chop_cnt >= gate_chopping_register[CHOP_W-1:0]) begin
      chop_cnt <= '0;
      chop     <= !chop;
    end else begin
      chop_cnt <= chop_cnt + 8'd1;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_phase
      logic        hi_ideal;
      logic        lo_ideal;
      logic [10:0] hi_dcnt;
      logic [10:0] lo_dcnt;
      logic        hi_dt;
      logic        lo_dt;
      logic        hi_rt;
      logic        lo_rt;
      logic [10:0] dead_cyc;

      always_comb begin
        dead_cyc = 11'(cfg.dead * DEAD_SCALE);
        // high side is on around the period centre for duty counts per half
        if (half) begin
          hi_ideal = {1'b0, half_cnt} < {1'b0, cfg.duty[p]};
        end else begin
          hi_ideal = {1'b0, half_cnt} + {1'b0, cfg.duty[p]} >= {1'b0, cfg.period};
        end
        // pulses shorter than the deletion width are dropped
        if (cfg.duty[p] < cfg.pdel) begin
          hi_ideal = 1'b0;
        end
        lo_ideal = !hi_ideal && !restart;
        if ({1'b0, cfg.period} < {1'b0, cfg.duty[p]} + {1'b0, cfg.pdel}) begin
          lo_ideal = 1'b0;
        end
        hi_dt = hi_ideal && (hi_dcnt >= dead_cyc);
        lo_dt = lo_ideal && (lo_dcnt >= dead_cyc);
        // crossover swaps the pair before the enables apply
        hi_rt = cfg.seg[SEG_XO_LSB + p] ? lo_dt : hi_dt;
        lo_rt = cfg.seg[SEG_XO_LSB + p] ? hi_dt : lo_dt;
      end

      // turn-on is delayed until the signal has been asked for dead_cyc cycles
      always_ff @(posedge sys_clk) begin
        if (sys_rst || shut_latched) begin
          hi_dcnt <= '0;
          lo_dcnt <= '0;
        end else begin
          hi_dcnt <= !hi_ideal ? 11'd0 : (hi_dcnt == 11'h7FF) ? hi_dcnt : hi_dcnt + 11'd1;
          lo_dcnt <= !lo_ideal ? 11'd0 : (lo_dcnt == 11'h7FF) ? lo_dcnt : lo_dcnt + 11'd1;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst || shut_latched) begin
          drive[2*p]   <= 1'b0;
          drive[2*p+1] <= 1'b0;
        end else begin
          drive[2*p]   <= hi_rt && cfg.seg[SEG_EN_LSB + 2*p]
                          && (!gate_chopping_register[GATE_HI_EN] || chop);
          drive[2*p+1] <= lo_rt && cfg.seg[SEG_EN_LSB + 2*p + 1]
                          && (!gate_chopping_register[GATE_LO_EN] || chop);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // gate drive: polarity and asynchronous shutdown
  // ****************************************************************
  // the trip pin and enabled gpio lines gate the pins without any flop, so the
  // outputs still go off with the clock stopped; enables come from flops
  logic       async_off;
  logic [5:0] pin_on;
  always_comb begin
    async_off = !trip_input_pin_n || |(~gpio_lines & io_shutdown_enable);
    pin_on    = drive & {6{!async_off}};
  end

  // polarity high gives active-high drive; off level is the inactive level
  always_comb begin
    phase_a_high_out = !(pin_on[0] ^ polarity_select_pin);
    phase_a_low_out  = !(pin_on[1] ^ polarity_select_pin);
    phase_b_high_out = !(pin_on[2] ^ polarity_select_pin);
    phase_b_low_out  = !(pin_on[3] ^ polarity_select_pin);
    phase_c_high_out = !(pin_on[4] ^ polarity_select_pin);
    phase_c_low_out  = !(pin_on[5] ^ polarity_select_pin);
  end

endmodule

// ### pwm_pkg.sv
// package for the three-phase pwm controller: register map, field layout,
// reset values and the shadow configuration carrier.
// assumes a 32-bit ahb-lite register bus with word-aligned registers.
package pwm_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_PERIOD   = 8'h00;
  localparam logic [7:0] ADDR_DEAD     = 8'h04;
  localparam logic [7:0] ADDR_PDEL     = 8'h08;
  localparam logic [7:0] ADDR_SYNCW    = 8'h0C;
  localparam logic [7:0] ADDR_DUTY_A   = 8'h10;
  localparam logic [7:0] ADDR_DUTY_B   = 8'h14;
  localparam logic [7:0] ADDR_DUTY_C   = 8'h18;
  localparam logic [7:0] ADDR_SEGMENT  = 8'h1C;
  localparam logic [7:0] ADDR_GATE     = 8'h20;
  localparam logic [7:0] ADDR_MODE     = 8'h24;
  localparam logic [7:0] ADDR_IO_SD_EN = 8'h28;
  localparam logic [7:0] ADDR_SW_TRIP  = 8'h2C;
  localparam logic [7:0] ADDR_STATUS   = 8'h30;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int DEAD_W        = 10;
  localparam int SYNCW_W       = 8;
  localparam int CHOP_W        = 8;
  localparam int SEG_EN_LSB    = 0;   // six enables: a_hi a_lo b_hi b_lo c_hi c_lo
  localparam int SEG_XO_LSB    = 6;   // three crossover bits, a b c
  localparam int GATE_HI_EN    = 8;
  localparam int GATE_LO_EN    = 9;
  localparam int MODE_DOUBLE   = 6;
  localparam int STAT_TRIP     = 0;
  localparam int STAT_POL      = 1;
  localparam int STAT_SHUT     = 2;
  localparam int STAT_HALF     = 3;
  localparam int SWT_TRIP_BIT  = 0;
  localparam int DEAD_SCALE    = 2;   // dead time counts in two-cycle steps

  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [7:0]  SYNCW_RST  = 8'h27;
  localparam logic [8:0]  SEG_RST    = 9'h03F;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ****************************************************************
  // shadow configuration latched at each update point
  // ****************************************************************
  typedef struct packed {
    logic [15:0]         period;
    logic [DEAD_W-1:0]   dead;
    logic [15:0]         pdel;
    logic [SYNCW_W-1:0]  syncw;
    logic [2:0][15:0]    duty;
    logic [8:0]          seg;
  } pwm_cfg_s;

endpackage

// ### gate_drive_model.sv
// gate-drive model: watches the six gate drives as an inverter's legs would.
// assumes the on level equals polarity_select_pin; it samples on falling sys_clk.
`timescale 1ns/1ns
// ****************************************
// shoot-through watch
// ****************************************
module gate_drive_model (
  input  wire logic       sys_clk,
  input  wire logic       polarity_select_pin,
  input  wire logic [5:0] gates,
  output logic      [2:0] shoot
);
  initial shoot = 3'h0;
  // sampled mid-cycle, so delta glitches on the async path are not counted
  always @(negedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (gates[2*i] == polarity_select_pin && gates[2*i+1] == polarity_select_pin) begin
        shoot[i] <= 1'b1;
      end
    end
  end
endmodule

// ### pwm_checker_sva.sv
// checker for the controller pins: shutdown, sync interrupt and pair overlap.
// assumes that it is bound into three_phase_pwm_controller and sees only its ports.
`timescale 1ns/1ns
module pwm_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic trip_input_pin_n,
  input wire logic polarity_select_pin,
  input wire logic phase_a_high_out,
  input wire logic phase_a_low_out,
  input wire logic phase_b_high_out,
  input wire logic phase_b_low_out,
  input wire logic phase_c_high_out,
  input wire logic phase_c_low_out,
  input wire logic sync_pulse_out,
  input wire logic sync_irq,
  input wire logic shutdown_irq
);
  logic [5:0] outs;
  assign outs = {phase_c_low_out, phase_c_high_out, phase_b_low_out,
                 phase_b_high_out, phase_a_low_out, phase_a_high_out};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // sequences and properties
  // ****************************************
  // two sync flops and the latch cycle pass before the timing unit stops
  sequence trip_held;
    !trip_input_pin_n [*5];
  endsequence
  sequence sync_start;
    $rose(sync_pulse_out);
  endsequence
  property pair_apart(logic hi, logic lo);
    !(hi == polarity_select_pin && lo == polarity_select_pin);
  endproperty
  a_trip_forces_off: assert property (!trip_input_pin_n |-> outs == {6{!polarity_select_pin}})
    else $error("outputs not off while trip pin low");
  a_trip_stops_sync: assert property (trip_held |-> !sync_pulse_out)
    else $error("sync runs during shutdown");
  a_trip_raises_irq: assert property ($fell(trip_input_pin_n) |-> ##[1:4] shutdown_irq)
    else $error("no shutdown interrupt after trip");
  a_shut_irq_pulse: assert property (shutdown_irq |=> !shutdown_irq)
    else $error("shutdown interrupt longer than one cycle");
  a_sync_irq_rise: assert property (sync_start |-> sync_irq)
    else $error("sync rise without interrupt");
  a_sync_irq_only: assert property (sync_irq |-> $rose(sync_pulse_out))
    else $error("sync interrupt without sync rise");
  a_pair_a_apart: assert property (pair_apart(outs[0], outs[1]))
    else $error("pair a both on");
  a_pair_b_apart: assert property (pair_apart(outs[2], outs[3]))
    else $error("pair b both on");
  a_pair_c_apart: assert property (pair_apart(outs[4], outs[5]))
    else $error("pair c both on");
endmodule

// ### tb_three_phase_pwm_controller.sv
// self-checking bench for the pwm controller, driven over ahb-lite.
// assumes zero wait states and a half-period count in the period register.
`timescale 1ns/1ns
module tb_three_phase_pwm_controller;
  import pwm_pkg::*;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, shoot;
  logic        hreadyout, hresp, sync_pulse_out, sync_irq, shutdown_irq;
  logic        trip_input_pin_n = 1'b1, polarity_select_pin = 1'b1;
  logic [11:0] gpio_lines = 12'hFFF;
  logic        phase_a_high_out, phase_a_low_out, phase_b_high_out;
  logic        phase_b_low_out, phase_c_high_out, phase_c_low_out;
  wire         hready = hreadyout;
  wire  [5:0]  outs = {phase_c_low_out, phase_c_high_out, phase_b_low_out,
                       phase_b_high_out, phase_a_low_out, phase_a_high_out};
  int          errors = 0, n_checks = 0, sd_irqs = 0, irqs, w, k;
  int          on_cnt [6];
  logic [7:0]  t_a1 [6] = '{ADDR_DEAD, ADDR_DEAD, ADDR_PDEL, ADDR_SEGMENT, ADDR_SEGMENT, ADDR_GATE};
  logic [31:0] t_d1 [6] = '{32'h5, 32'h0, 32'h0, 32'h7F, 32'h3F, 32'h201};
  logic [7:0]  t_a2 [6] = '{ADDR_PDEL, ADDR_PDEL, ADDR_SEGMENT, ADDR_GATE, ADDR_GATE, ADDR_GATE};
  logic [31:0] t_d2 [6] = '{32'h0, 32'h28, 32'h3E, 32'h0, 32'h101, 32'h201};
  int          t_hi [6] = '{50, 0, 0, 140, 30, 60};
  int          t_lo [6] = '{130, 200, 140, 60, 140, 70};

  three_phase_pwm_controller three_phase_pwm_controller_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trip_input_pin_n(trip_input_pin_n),
    .polarity_select_pin(polarity_select_pin), .gpio_lines(gpio_lines),
    .phase_a_high_out(phase_a_high_out), .phase_a_low_out(phase_a_low_out),
    .phase_b_high_out(phase_b_high_out), .phase_b_low_out(phase_b_low_out),
    .phase_c_high_out(phase_c_high_out), .phase_c_low_out(phase_c_low_out),
    .sync_pulse_out(sync_pulse_out), .sync_irq(sync_irq), .shutdown_irq(shutdown_irq));
  gate_drive_model gate_drive_model_i (.sys_clk(sys_clk),
    .polarity_select_pin(polarity_select_pin), .gates(outs), .shoot(shoot));

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (shutdown_irq === 1'b1) sd_irqs <= sd_irqs + 1;

  // ****************************************
  // bus, timing and compare tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= HTRANS_NONSEQ; hwrite <= wr; haddr <= {24'h000000, a};
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task wait_rise;
    w = 0;
    while (sync_pulse_out !== 1'b0 && w < 2000) begin @(negedge sys_clk); w++; end
    while (sync_pulse_out !== 1'b1 && w < 2000) begin @(negedge sys_clk); w++; end
    if (w >= 2000) chk(32'h0, 32'h1);
  endtask
  // a rise seen in the second half is a midpoint, so the next is a period start;
  // single mode has no midpoint rise, so a first-half rise ends the wait at once
  task period_start;
    wait_rise;
    xfer(1'b0, ADDR_STATUS, 32'h0);
    if (rd[STAT_HALF] !== 1'b0) wait_rise;
  endtask
  // counts on-cycles of each drive and sync interrupts over n cycles
  task measure(input int n);
    for (int i = 0; i < 6; i++) on_cnt[i] = 0;
    irqs = 0;
    repeat (n) begin
      @(negedge sys_clk);
      for (int i = 0; i < 6; i++) if (outs[i] === polarity_select_pin) on_cnt[i]++;
      if (sync_irq === 1'b1) irqs++;
    end
  endtask
  task chk_off;
    chk({26'h0, outs}, {26'h0, {6{~polarity_select_pin}}});
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    xfer(1'b0, ADDR_SYNCW, 32'h0); chk(rd, 32'h27);
    xfer(1'b0, ADDR_MODE, 32'h0); chk(rd, 32'h0);
    xfer(1'b0, ADDR_SEGMENT, 32'h0); chk(rd, 32'h3F);
    xfer(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
    $display("test reset values done");
    xfer(1'b1, ADDR_PERIOD, 32'h64); xfer(1'b1, ADDR_SYNCW, 32'h4);
    xfer(1'b1, ADDR_DUTY_A, 32'h1E); xfer(1'b1, ADDR_DUTY_B, 32'h32);
    xfer(1'b1, ADDR_DUTY_C, 32'h46);
    wait_rise; wait_rise; k = 0;
    while (sync_pulse_out === 1'b1 && k < 300) begin k++; @(negedge sys_clk); end
    chk(k, 5);
    period_start; measure(200);
    chk(on_cnt[0], 60); chk(on_cnt[1], 140);
    chk(on_cnt[2], 100); chk(on_cnt[4], 140); chk(irqs, 1);
    wait_rise; xfer(1'b0, ADDR_STATUS, 32'h0); chk(rd[3:0], 4'h3);
    repeat (100) @(posedge sys_clk);
    xfer(1'b0, ADDR_STATUS, 32'h0); chk(rd[3:0], 4'hB);
    $display("test period and status done");
    for (int c = 0; c < 6; c++) begin
      xfer(1'b1, t_a1[c], t_d1[c]); xfer(1'b1, t_a2[c], t_d2[c]);
      period_start; period_start; measure(200);
      chk(on_cnt[0], t_hi[c]); chk(on_cnt[1], t_lo[c]);
    end
    xfer(1'b1, ADDR_GATE, 32'h0);
    $display("test config table done");
    period_start; period_start;
    fork measure(200); xfer(1'b1, ADDR_DUTY_A, 32'h32); join
    chk(on_cnt[0], 60); measure(200); chk(on_cnt[0], 100);
    xfer(1'b1, ADDR_DUTY_A, 32'h1E); xfer(1'b1, ADDR_MODE, 32'h40);
    period_start; period_start;
    fork measure(200); xfer(1'b1, ADDR_DUTY_A, 32'h32); join
    chk(on_cnt[0], 80); chk(irqs, 2);
    xfer(1'b1, ADDR_MODE, 32'h0); xfer(1'b1, ADDR_DUTY_A, 32'h1E);
    $display("test update modes done");
    k = sd_irqs;
    @(posedge sys_clk); trip_input_pin_n <= 1'b0; #5;
    chk_off;
    repeat (10) @(posedge sys_clk);
    chk(sd_irqs, k + 1); trip_input_pin_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk_off; xfer(1'b0, ADDR_STATUS, 32'h0); chk(rd[2:0], 3'h7);
    xfer(1'b1, ADDR_SW_TRIP, 32'h0); period_start; measure(200); chk(on_cnt[1], 140);
    xfer(1'b1, ADDR_IO_SD_EN, 32'h8);
    @(posedge sys_clk); gpio_lines <= 12'hFFB; #5;
    chk({31'h0, outs[0] ^ outs[1]}, 32'h1);
    @(posedge sys_clk); gpio_lines <= 12'hFF7; #5;
    chk_off;
    repeat (5) @(posedge sys_clk);
    gpio_lines <= 12'hFFF; xfer(1'b1, ADDR_SW_TRIP, 32'h0);
    k = sd_irqs; xfer(1'b1, ADDR_SW_TRIP, 32'h1);
    repeat (5) @(posedge sys_clk);
    chk_off; chk(sd_irqs, k + 1);
    xfer(1'b1, ADDR_SW_TRIP, 32'h0);
    $display("test shutdown done");
    @(posedge sys_clk); polarity_select_pin <= 1'b0;
    period_start; measure(200); chk(on_cnt[0], 60);
    xfer(1'b0, ADDR_STATUS, 32'h0); chk(rd[STAT_POL], 1'b0);
    chk(shoot, 3'h0);
    $display("test polarity done");
    wrap_up;
  end

  initial begin
    #2000000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule

bind three_phase_pwm_controller pwm_checker pwm_checker_i (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .trip_input_pin_n(trip_input_pin_n),
  .polarity_select_pin(polarity_select_pin), .phase_a_high_out(phase_a_high_out),
  .phase_a_low_out(phase_a_low_out), .phase_b_high_out(phase_b_high_out),
  .phase_b_low_out(phase_b_low_out), .phase_c_high_out(phase_c_high_out),
  .phase_c_low_out(phase_c_low_out), .sync_pulse_out(sync_pulse_out),
  .sync_irq(sync_irq), .shutdown_irq(shutdown_irq));
